// ==== verilog/fcpc_pkg.sv ====
// Purpose: Shared constants and types for the flash command and protect controller
// Assumes: 50 MHz system clock; flash pins are asynchronous to it
// Notes:   Unlock values and the autoselect command byte are parameters with plain defaults
package fcpc_pkg;
	localparam int unsigned CLK_MHZ        = 50;
	localparam int unsigned AW             = 18;
	localparam int unsigned DW             = 8;
	// Strobe timing in ns, converted to cycles (least times round up)
	localparam int unsigned T_SETUP_NS     = 40;
	localparam int unsigned T_PULSE_NS     = 60;
	localparam int unsigned T_HOLD_NS      = 40;
	localparam int unsigned T_SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_PULSE_CYC    = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_HOLD_CYC     = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_ACC_NS       = 100;
	localparam int unsigned T_ACC_CYC      = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  CNT_RST        = 8'h00;
	// Default command values; arbitrary, override per part
	localparam logic [AW-1:0] UNL1_ADDR    = 18'h00555;
	localparam logic [AW-1:0] UNL2_ADDR    = 18'h002aa;
	localparam logic [DW-1:0] UNL1_DATA    = 8'haa;
	localparam logic [DW-1:0] UNL2_DATA    = 8'h55;
	localparam logic [DW-1:0] CMD_RESET    = 8'hf0;
	localparam logic [DW-1:0] CMD_AUTOSEL  = 8'h90;
	localparam logic [DW-1:0] CMD_PROGRAM  = 8'ha0;
	localparam logic [DW-1:0] CMD_ERASE    = 8'h80;
	localparam logic [DW-1:0] CMD_SECERASE = 8'h30;
	// Autoselect low addresses
	localparam logic [7:0]  AS_MFR_ADDR    = 8'h00;
	localparam logic [7:0]  AS_DEV_ADDR    = 8'h01;
	localparam logic [7:0]  AS_PROT_ADDR   = 8'h02;
	localparam logic [DW-1:0] AS_PROT_YES  = 8'h01;
	// Register map, Avalon word addresses
	localparam logic [3:0]  REG_CTRL       = 4'h0;
	localparam logic [3:0]  REG_ADDR       = 4'h1;
	localparam logic [3:0]  REG_DATA       = 4'h2;
	localparam logic [3:0]  REG_STATUS     = 4'h3;
	localparam logic [3:0]  REG_RDATA      = 4'h4;
	// Operation codes in the control register
	typedef enum logic [2:0] {
		FCPC_OP_READ, FCPC_OP_RESET, FCPC_OP_AUTOSEL, FCPC_OP_PROGRAM,
		FCPC_OP_SECERASE, FCPC_OP_RAW
	} fcpc_op_e;
	// One bus cycle on the flash pins
	typedef struct packed {
		logic          wr;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
	} fcpc_cyc_s;
endpackage : fcpc_pkg

// ==== verilog/fcpc_cycle.sv ====
// Purpose: Runs one read or write strobe cycle on the flash pins
// Assumes: Timing counts from the package; pins decoded from state and cycle flops
// Notes:   Address set before strobes fall, data held past the rising edge
`timescale 1ns/1ns
`default_nettype none
module fcpc_cycle (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        start_i,
	input  wire fcpc_pkg::fcpc_cyc_s         cyc_i,
	input  wire logic [fcpc_pkg::DW-1:0]     dq_sync_i,
	output logic                             done_o,
	output logic [fcpc_pkg::DW-1:0]          rdata_o,
	output logic                             ce_n_o,
	output logic                             oe_n_o,
	output logic                             we_n_o,
	output logic [fcpc_pkg::AW-1:0]          a_o,
	output logic [fcpc_pkg::DW-1:0]          dq_o,
	output logic                             dq_oe_o
);
	typedef enum logic [1:0] {FCPC_C_IDLE, FCPC_C_SETUP, FCPC_C_PULSE, FCPC_C_HOLD} fcpc_cst_e;
	fcpc_cst_e                st_q, st_d;
	logic [7:0]               cnt_q, cnt_d;
	fcpc_pkg::fcpc_cyc_s      cyc_q, cyc_d;
	logic [fcpc_pkg::DW-1:0]  rd_q, rd_d;
	logic                     done_d, done_q;

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		cyc_d  = cyc_q;
		rd_d   = rd_q;
		done_d = 1'b0;
		unique case (st_q)
			FCPC_C_IDLE: begin
				if (start_i) begin
					cyc_d = cyc_i;
					cnt_d = 8'(fcpc_pkg::T_SETUP_CYC);
					st_d  = FCPC_C_SETUP;
				end
			end
			FCPC_C_SETUP: begin
				if (cnt_q <= 8'h01) begin
					// Pulse length covers both write pulse and read access
					cnt_d = cyc_q.wr ? 8'(fcpc_pkg::T_PULSE_CYC)
					                 : 8'(fcpc_pkg::T_ACC_CYC + 2);
					st_d  = FCPC_C_PULSE;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			FCPC_C_PULSE: begin
				if (cnt_q <= 8'h01) begin
					rd_d  = dq_sync_i;
					cnt_d = 8'(fcpc_pkg::T_HOLD_CYC);
					st_d  = FCPC_C_HOLD;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			FCPC_C_HOLD: begin
				if (cnt_q <= 8'h01) begin
					done_d = 1'b1;
					st_d   = FCPC_C_IDLE;
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q   <= FCPC_C_IDLE;
			cnt_q  <= fcpc_pkg::CNT_RST;
			cyc_q  <= '0;
			rd_q   <= '0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			cyc_q  <= cyc_d;
			rd_q   <= rd_d;
			done_q <= done_d;
		end
	end

	// Write only with CE and WE low and OE high; OE kept high across writes
	always_comb begin
		ce_n_o  = !(st_q == FCPC_C_PULSE);
		we_n_o  = !(st_q == FCPC_C_PULSE && cyc_q.wr);
		oe_n_o  = !(st_q == FCPC_C_PULSE && !cyc_q.wr);
		dq_oe_o = cyc_q.wr && st_q != FCPC_C_IDLE;
	end
	// Address stable from setup so the later falling edge latches it
	assign a_o     = cyc_q.addr;
	// Data held through hold so the earlier rising edge latches it
	assign dq_o    = cyc_q.data;
	assign done_o  = done_q;
	assign rdata_o = rd_q;
endmodule : fcpc_cycle
`default_nettype wire

// ==== verilog/fcpc_ctrl.sv ====
// Purpose: Host controller issuing command sequences to a parallel flash
// Assumes: Avalon-MM slave with waitrequest; flash pins asynchronous
// Notes:   One operation at a time; busy until the whole sequence is out
//
// How it works
// - Host protects every unprotected sector before the first unprotect write; the controller leaves protect cycles to software raw writes.
// - Host writes both unlock cycles before every program or erase command.
// - Write only when chip select and write strobe low, output enable high.
// - After time-limit-exceeded bit rises, host writes the reset command; the controller only sets the status bit, software issues the reset op.
// - Autoselect entered by two unlock cycles and the autoselect command.
`timescale 1ns/1ns
`default_nettype none
module fcpc_ctrl #(
	parameter logic [fcpc_pkg::AW-1:0] UNL1_ADDR   = fcpc_pkg::UNL1_ADDR,
	parameter logic [fcpc_pkg::AW-1:0] UNL2_ADDR   = fcpc_pkg::UNL2_ADDR,
	parameter logic [fcpc_pkg::DW-1:0] UNL1_DATA   = fcpc_pkg::UNL1_DATA,
	parameter logic [fcpc_pkg::DW-1:0] UNL2_DATA   = fcpc_pkg::UNL2_DATA,
	parameter logic [fcpc_pkg::DW-1:0] AUTOSEL_CMD = fcpc_pkg::CMD_AUTOSEL
) (
	input  wire logic                     CLOCK_I,
	input  wire logic                     RST_N_I,
	input  wire logic [3:0]               AVS_ADDRESS_I,
	input  wire logic                     AVS_READ_I,
	input  wire logic                     AVS_WRITE_I,
	input  wire logic [31:0]              AVS_WRITEDATA_I,
	output logic [31:0]                   AVS_READDATA_O,
	output logic                          AVS_WAITREQUEST_O,
	output logic                          FL_CE_N_O,
	output logic                          FL_OE_N_O,
	output logic                          FL_WE_N_O,
	output logic [fcpc_pkg::AW-1:0]       FL_ADDR_O,
	output logic [fcpc_pkg::DW-1:0]       FL_DQ_O,
	output logic                          FL_DQ_OE_O,
	input  wire logic [fcpc_pkg::DW-1:0]  FL_DQ_I,
	output logic                          FL_RESET_N_O,
	output logic                          FL_HIGH_VOLTAGE_EN_O
);
	typedef enum logic [2:0] {FCPC_S_IDLE, FCPC_S_ISSUE, FCPC_S_WAIT, FCPC_S_NEXT} fcpc_st_e;

	logic [fcpc_pkg::DW-1:0] dq_s1_q, dq_s2_q;
	fcpc_st_e                st_q, st_d;
	logic [2:0]              op_q, op_d;
	logic [2:0]              step_q, step_d;
	logic [2:0]              nsteps;
	logic [fcpc_pkg::AW-1:0] addr_q, addr_d;
	logic [fcpc_pkg::DW-1:0] data_q, data_d;
	logic [fcpc_pkg::DW-1:0] rdata_q, rdata_d;
	logic                    autosel_q, autosel_d;
	logic                    hv_q, hv_d;
	logic                    frst_q, frst_d;
	logic                    err_q, err_d;
	logic                    embed_q, embed_d;
	logic                    start;
	fcpc_pkg::fcpc_cyc_s     cyc;
	logic                    cyc_done;
	logic [fcpc_pkg::DW-1:0] cyc_rdata;
	logic                    busy;
	logic                    bus_wr, bus_rd;

	// Two flops before anything looks at the data pins
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			dq_s1_q <= FL_DQ_I;
			dq_s2_q <= dq_s1_q;
		end
	end

	assign busy   = st_q != FCPC_S_IDLE;
	assign bus_wr = AVS_WRITE_I && !AVS_READ_I;
	assign bus_rd = AVS_READ_I && !AVS_WRITE_I;
	// Control writes stall while a sequence runs; all else answers at once
	assign AVS_WAITREQUEST_O = bus_wr && AVS_ADDRESS_I == fcpc_pkg::REG_CTRL && busy;

	// Cycle count per operation; unlocks lead every program and erase
	always_comb begin
		unique case (op_q)
			3'(fcpc_pkg::FCPC_OP_RESET):    nsteps = 3'd1;
			3'(fcpc_pkg::FCPC_OP_AUTOSEL):  nsteps = 3'd3;
			3'(fcpc_pkg::FCPC_OP_PROGRAM):  nsteps = 3'd4;
			3'(fcpc_pkg::FCPC_OP_SECERASE): nsteps = 3'd6;
			default:                        nsteps = 3'd1;
		endcase
	end

	// Address and data of the current step
	always_comb begin
		cyc.wr   = 1'b1;
		cyc.addr = UNL1_ADDR;
		cyc.data = UNL1_DATA;
		unique case (op_q)
			3'(fcpc_pkg::FCPC_OP_READ): begin
				cyc.wr   = 1'b0;
				cyc.addr = addr_q;
			end
			3'(fcpc_pkg::FCPC_OP_RAW): begin
				// Software orders its own protect cycles through raw writes
				cyc.addr = addr_q;
				cyc.data = data_q;
			end
			3'(fcpc_pkg::FCPC_OP_RESET): begin
				cyc.addr = addr_q;
				cyc.data = fcpc_pkg::CMD_RESET;
			end
			default: begin
				// Unlock pair before the command byte
				if (step_q == 3'd1 || step_q == 3'd4) begin
					cyc.addr = UNL2_ADDR;
					cyc.data = UNL2_DATA;
				end else if (step_q == 3'd2) begin
					cyc.addr = UNL1_ADDR;
					unique case (op_q)
						3'(fcpc_pkg::FCPC_OP_AUTOSEL): cyc.data = AUTOSEL_CMD;
						3'(fcpc_pkg::FCPC_OP_PROGRAM): cyc.data = fcpc_pkg::CMD_PROGRAM;
						default:                       cyc.data = fcpc_pkg::CMD_ERASE;
					endcase
				end else if (step_q == 3'd3 && op_q == 3'(fcpc_pkg::FCPC_OP_PROGRAM)) begin
					cyc.addr = addr_q;
					cyc.data = data_q;
				end else if (step_q == 3'd5) begin
					cyc.addr = addr_q;
					cyc.data = fcpc_pkg::CMD_SECERASE;
				end
			end
		endcase
	end

	always_comb begin
		st_d      = st_q;
		op_d      = op_q;
		step_d    = step_q;
		addr_d    = addr_q;
		data_d    = data_q;
		rdata_d   = rdata_q;
		autosel_d = autosel_q;
		hv_d      = hv_q;
		frst_d    = frst_q;
		err_d     = err_q;
		embed_d   = embed_q;
		start     = 1'b0;
		if (bus_wr && AVS_ADDRESS_I == fcpc_pkg::REG_ADDR) begin
			addr_d = AVS_WRITEDATA_I[fcpc_pkg::AW-1:0];
		end
		if (bus_wr && AVS_ADDRESS_I == fcpc_pkg::REG_DATA) begin
			data_d = AVS_WRITEDATA_I[fcpc_pkg::DW-1:0];
		end
		unique case (st_q)
			FCPC_S_IDLE: begin
				if (bus_wr && AVS_ADDRESS_I == fcpc_pkg::REG_CTRL) begin
					op_d   = AVS_WRITEDATA_I[2:0];
					hv_d   = AVS_WRITEDATA_I[4];
					frst_d = AVS_WRITEDATA_I[5];
					// A bare pin write leaves no command to send
					// A held flash reset swallows every cycle, so none is started
					if (AVS_WRITEDATA_I[3] && !AVS_WRITEDATA_I[5]) begin
						step_d = 3'd0;
						st_d   = FCPC_S_ISSUE;
						// Each new go starts with a clean time-out flag
						err_d  = 1'b0;
					end
				end
			end
			FCPC_S_ISSUE: begin
				start = 1'b1;
				st_d  = FCPC_S_WAIT;
			end
			FCPC_S_WAIT: begin
				if (cyc_done) begin
					if (!cyc.wr) begin
						rdata_d = cyc_rdata;
						// Bit 5 means a time-out only while an embedded op may run;
						// plain array data with that bit set must not raise the flag
						if (cyc_rdata[5] && embed_q && !autosel_q) begin
							err_d = 1'b1;
						end
					end
					st_d = FCPC_S_NEXT;
				end
			end
			FCPC_S_NEXT: begin
				if (step_q + 3'd1 >= nsteps) begin
					st_d = FCPC_S_IDLE;
					// Reads after a program or erase may be status polls
					if (op_q == 3'(fcpc_pkg::FCPC_OP_PROGRAM) ||
					    op_q == 3'(fcpc_pkg::FCPC_OP_SECERASE) ||
					    op_q == 3'(fcpc_pkg::FCPC_OP_RAW)) begin
						embed_d = 1'b1;
					end else if (op_q != 3'(fcpc_pkg::FCPC_OP_READ)) begin
						embed_d = 1'b0;
					end
					if (op_q == 3'(fcpc_pkg::FCPC_OP_AUTOSEL)) begin
						autosel_d = 1'b1;
					end else if (op_q == 3'(fcpc_pkg::FCPC_OP_RESET)) begin
						autosel_d = 1'b0;
						err_d     = 1'b0;
					end
				end else begin
					step_d = step_q + 3'd1;
					st_d   = FCPC_S_ISSUE;
				end
			end
			default: st_d = FCPC_S_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_q      <= FCPC_S_IDLE;
			op_q      <= 3'h0;
			step_q    <= 3'h0;
			addr_q    <= '0;
			data_q    <= '0;
			rdata_q   <= '0;
			autosel_q <= 1'b0;
			hv_q      <= 1'b0;
			frst_q    <= 1'b0;
			err_q     <= 1'b0;
			embed_q   <= 1'b0;
		end else begin
			st_q      <= st_d;
			op_q      <= op_d;
			step_q    <= step_d;
			addr_q    <= addr_d;
			data_q    <= data_d;
			rdata_q   <= rdata_d;
			autosel_q <= autosel_d;
			hv_q      <= hv_d;
			frst_q    <= frst_d;
			err_q     <= err_d;
			embed_q   <= embed_d;
		end
	end

	// Status: busy, autoselect entered, time limit seen, high voltage on
	always_comb begin
		AVS_READDATA_O = 32'h0000_0000;
		if (bus_rd) begin
			unique case (AVS_ADDRESS_I)
				fcpc_pkg::REG_CTRL:   AVS_READDATA_O = {26'h0, frst_q, hv_q, 1'b0, op_q};
				fcpc_pkg::REG_ADDR:   AVS_READDATA_O = {14'h0, addr_q};
				fcpc_pkg::REG_DATA:   AVS_READDATA_O = {24'h0, data_q};
				fcpc_pkg::REG_STATUS: AVS_READDATA_O = {28'h0, hv_q, err_q, autosel_q, busy};
				fcpc_pkg::REG_RDATA:  AVS_READDATA_O = {24'h0, rdata_q};
				default:              AVS_READDATA_O = 32'h0000_0000;
			endcase
		end
	end

	assign FL_RESET_N_O         = !frst_q;
	assign FL_HIGH_VOLTAGE_EN_O = hv_q;

	fcpc_cycle u_cycle (
		.clk_i     (CLOCK_I),
		.rst_n_i   (RST_N_I),
		.start_i   (start),
		.cyc_i     (cyc),
		.dq_sync_i (dq_s2_q),
		.done_o    (cyc_done),
		.rdata_o   (cyc_rdata),
		.ce_n_o    (FL_CE_N_O),
		.oe_n_o    (FL_OE_N_O),
		.we_n_o    (FL_WE_N_O),
		.a_o       (FL_ADDR_O),
		.dq_o      (FL_DQ_O),
		.dq_oe_o   (FL_DQ_OE_O)
	);
endmodule : fcpc_ctrl
`default_nettype wire

// ==== verif/fcpc_ctrl_checker.sv ====
// Purpose: Port checks for the flash command and protect controller
// Assumes: One clock domain, reset asynchronous active low
// Notes:   Strobe widths follow the hand-over timing
`timescale 1ns/1ns
`default_nettype none
module fcpc_ctrl_checker (
	input  wire logic                     CLOCK_I,
	input  wire logic                     RST_N_I,
	input  wire logic [3:0]               AVS_ADDRESS_I,
	input  wire logic                     AVS_READ_I,
	input  wire logic                     AVS_WRITE_I,
	input  wire logic [31:0]              AVS_WRITEDATA_I,
	input  wire logic [31:0]              AVS_READDATA_O,
	input  wire logic                     AVS_WAITREQUEST_O,
	input  wire logic                     FL_CE_N_O,
	input  wire logic                     FL_OE_N_O,
	input  wire logic                     FL_WE_N_O,
	input  wire logic [fcpc_pkg::AW-1:0]  FL_ADDR_O,
	input  wire logic [fcpc_pkg::DW-1:0]  FL_DQ_O,
	input  wire logic                     FL_DQ_OE_O,
	input  wire logic [fcpc_pkg::DW-1:0]  FL_DQ_I,
	input  wire logic                     FL_RESET_N_O,
	input  wire logic                     FL_HIGH_VOLTAGE_EN_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	write_qual_a: assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_OE_N_O && FL_DQ_OE_O)
		else $error("write strobe without chip select or with output enable");
	read_qual_a: assert property (!FL_OE_N_O |-> FL_WE_N_O && !FL_DQ_OE_O && !FL_CE_N_O)
		else $error("read strobe overlaps a write or a driven bus");
	addr_set_a: assert property (!FL_WE_N_O |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O))
		else $error("address or data moved during the write pulse");
	data_hold_a: assert property ($rose(FL_WE_N_O) |-> FL_DQ_OE_O && $stable(FL_DQ_O))
		else $error("write data not held at the strobe rise");
	wr_pulse_a: assert property ($fell(FL_WE_N_O) |-> !FL_WE_N_O [*3] ##1 FL_WE_N_O)
		else $error("write pulse width wrong");
	rd_pulse_a: assert property ($fell(FL_OE_N_O) |-> !FL_OE_N_O [*7] ##1 FL_OE_N_O)
		else $error("read pulse width wrong");
	ctrl_pins_a: assert property (AVS_WRITE_I && !AVS_WAITREQUEST_O &&
		AVS_ADDRESS_I == fcpc_pkg::REG_CTRL |=> FL_HIGH_VOLTAGE_EN_O ==
		$past(AVS_WRITEDATA_I[4]) && FL_RESET_N_O == !$past(AVS_WRITEDATA_I[5]))
		else $error("high voltage or reset pin does not follow control");
	wait_only_a: assert property (AVS_WAITREQUEST_O |-> AVS_WRITE_I &&
		AVS_ADDRESS_I == fcpc_pkg::REG_CTRL)
		else $error("waitrequest outside a control write");
	rdata_idle_a: assert property (!AVS_READ_I || AVS_ADDRESS_I > 4'h4 |-> AVS_READDATA_O == 32'h0)
		else $error("read data not zero when idle or unmapped");
	cover property ($fell(FL_WE_N_O));
	cover property ($fell(FL_OE_N_O));
	cover property (FL_HIGH_VOLTAGE_EN_O && !FL_WE_N_O);
endmodule : fcpc_ctrl_checker
bind fcpc_ctrl fcpc_ctrl_checker i_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
	.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .FL_CE_N_O(FL_CE_N_O), .FL_OE_N_O(FL_OE_N_O),
	.FL_WE_N_O(FL_WE_N_O), .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O),
	.FL_DQ_OE_O(FL_DQ_OE_O), .FL_DQ_I(FL_DQ_I), .FL_RESET_N_O(FL_RESET_N_O),
	.FL_HIGH_VOLTAGE_EN_O(FL_HIGH_VOLTAGE_EN_O));
`default_nettype wire

// ==== verif/fcpc_flash_model.sv ====
// Purpose: Behavioural parallel flash with command decode and sector protect
// Assumes: Four sectors on the top two address bits, 16 bytes kept each
// Notes:   Strobe edges and the reset pin's falling edge drive everything; no clock
`timescale 1ns/1ns
`default_nettype none
module fcpc_flash_model #(
	parameter logic [3:0] PROT_INIT = 4'h0,
	parameter logic [7:0] MFR_CODE  = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_CODE  = 8'h3c  // Arbitrary value
) (
	input  wire logic                     ce_n_i,
	input  wire logic                     oe_n_i,
	input  wire logic                     we_n_i,
	input  wire logic [fcpc_pkg::AW-1:0]  addr_i,
	input  wire logic [fcpc_pkg::DW-1:0]  dq_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     hv_i,
	output logic [fcpc_pkg::DW-1:0]       dq_o
);
	logic [7:0]  mem [64];
	logic [3:0]  prot;
	logic [3:0]  st;
	logic [17:0] lat_a;
	logic [7:0]  rd;
	logic        wr_n;
	assign wr_n = ce_n_i | we_n_i | !oe_n_i;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		prot = PROT_INIT;
		st = 4'd0;
	end
	always @(negedge rst_n_i) st = 4'd0;
	always @(negedge wr_n) lat_a = addr_i;
	always @(posedge wr_n) begin : cmd
		logic ok;
		ok = !prot[lat_a[17:16]] || hv_i;
		// A strobe rising before power and pins settle carries no command
		if ($isunknown({lat_a, dq_i})) st = 4'd0;
		else if (dq_i == fcpc_pkg::CMD_RESET && st != 4'd3) st = 4'd0;
		else case (st)
			4'd0, 4'd5: st = (lat_a == fcpc_pkg::UNL1_ADDR && dq_i == fcpc_pkg::UNL1_DATA) ?
				st + 4'd1 : 4'd0;
			4'd1, 4'd6: st = (lat_a == fcpc_pkg::UNL2_ADDR && dq_i == fcpc_pkg::UNL2_DATA) ?
				st + 4'd1 : 4'd0;
			4'd2: st = dq_i == fcpc_pkg::CMD_AUTOSEL ? 4'd4 : dq_i == fcpc_pkg::CMD_PROGRAM ?
				4'd3 : dq_i == fcpc_pkg::CMD_ERASE ? 4'd5 : 4'd0;
			4'd3: begin
				if (ok) mem[{lat_a[17:16], lat_a[3:0]}] &= dq_i;
				st = 4'd0;
			end
			4'd4: st = 4'd4;
			4'd7: begin
				if (ok && dq_i == fcpc_pkg::CMD_SECERASE)
					for (int i = 0; i < 16; i++) mem[{lat_a[17:16], i[3:0]}] = 8'hff;
				st = 4'd0;
			end
			default: st = 4'd0;
		endcase
	end
	always_comb begin
		rd = mem[{addr_i[17:16], addr_i[3:0]}];
		if (st == 4'd4) case (addr_i[7:0])
			fcpc_pkg::AS_MFR_ADDR: rd = MFR_CODE;
			fcpc_pkg::AS_DEV_ADDR: rd = DEV_CODE;
			fcpc_pkg::AS_PROT_ADDR: rd = {7'h0, prot[addr_i[17:16]]};
			default: rd = 8'h00;
		endcase
	end
	// Released bus shows the inverse so a stale sample cannot pass
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
endmodule : fcpc_flash_model
`default_nettype wire

// ==== verif/fcpc_ctrl_tb.sv ====
// Purpose: Register-level tests of the controller against the flash model
// Assumes: Sector 1 of the model starts protected
// Notes:   Every operation is polled to completion through the status register
`timescale 1ns/1ns
`default_nettype none
module fcpc_ctrl_tb;
	localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
	localparam logic [7:0] DEV = 8'h3c; // Arbitrary value
	logic                    clk, rst_n, rd, wr, wait_req, hv, ce_n, oe_n, we_n, dq_oe;
	logic                    rst_pin, hv_pin;
	logic [3:0]              adr;
	logic [31:0]             wdat, rdat, v;
	logic [17:0]             fa;
	logic [7:0]              fdo, fdi;
	int                      error_cnt, check_count;
	fcpc_ctrl i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
		.AVS_WAITREQUEST_O(wait_req), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n),
		.FL_ADDR_O(fa), .FL_DQ_O(fdo), .FL_DQ_OE_O(dq_oe), .FL_DQ_I(fdi),
		.FL_RESET_N_O(rst_pin), .FL_HIGH_VOLTAGE_EN_O(hv_pin));
	fcpc_flash_model #(.PROT_INIT(4'h2), .MFR_CODE(MFR), .DEV_CODE(DEV)) i_flash (
		.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(fdo),
		.rst_n_i(rst_pin), .hv_i(hv_pin), .dq_o(fdi));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		adr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		while (wait_req !== 1'b0) @(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : av_wr
	task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		while (wait_req !== 1'b0) @(posedge clk);
		d = rdat;
		rd <= 1'b0;
		@(posedge clk);
	endtask : av_rd
	task automatic op(input fcpc_pkg::fcpc_op_e code, input logic [17:0] a, input logic [7:0] d);
		logic [31:0] s;
		av_wr(fcpc_pkg::REG_ADDR, {14'h0, a});
		av_wr(fcpc_pkg::REG_DATA, {24'h0, d});
		av_wr(fcpc_pkg::REG_CTRL, {26'h0, 1'b0, hv, 1'b1, code});
		s = 32'h1;
		while (s[0] !== 1'b0) av_rd(fcpc_pkg::REG_STATUS, s);
	endtask : op
	task automatic rd_chk(input logic [17:0] a, input logic [7:0] exp);
		op(fcpc_pkg::FCPC_OP_READ, a, 8'h00);
		av_rd(fcpc_pkg::REG_RDATA, v);
		check("read data", {24'h0, v[7:0]}, {24'h0, exp});
	endtask : rd_chk
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 4'h0;
		wdat = 32'h0;
		hv = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(18'h00005, 8'hff);
		op(fcpc_pkg::FCPC_OP_PROGRAM, 18'h00005, 8'h3c);
		rd_chk(18'h00005, 8'h3c);
		op(fcpc_pkg::FCPC_OP_PROGRAM, 18'h10005, 8'h12);
		rd_chk(18'h10005, 8'hff);
		hv = 1'b1;
		op(fcpc_pkg::FCPC_OP_PROGRAM, 18'h10005, 8'h12);
		av_rd(fcpc_pkg::REG_STATUS, v);
		check("status hv", {31'h0, v[3]}, 32'h1);
		hv = 1'b0;
		op(fcpc_pkg::FCPC_OP_SECERASE, 18'h10000, 8'h00);
		rd_chk(18'h10005, 8'h12);
		op(fcpc_pkg::FCPC_OP_AUTOSEL, 18'h00000, 8'h00);
		av_rd(fcpc_pkg::REG_STATUS, v);
		check("status autoselect", {31'h0, v[1]}, 32'h1);
		rd_chk(18'h00000, MFR);
		rd_chk(18'h00001, DEV);
		rd_chk(18'h10002, 8'h01);
		rd_chk(18'h00002, 8'h00);
		rd_chk(18'h00000, MFR);
		op(fcpc_pkg::FCPC_OP_RESET, 18'h2abcd, 8'h00);
		rd_chk(18'h00005, 8'h3c);
		av_rd(fcpc_pkg::REG_STATUS, v);
		check("status after reset", {30'h0, v[2:1]}, 32'h0);
		op(fcpc_pkg::FCPC_OP_SECERASE, 18'h00000, 8'h00);
		rd_chk(18'h00005, 8'hff);
		op(fcpc_pkg::FCPC_OP_RAW, fcpc_pkg::UNL1_ADDR, fcpc_pkg::UNL1_DATA);
		op(fcpc_pkg::FCPC_OP_RAW, fcpc_pkg::UNL2_ADDR, fcpc_pkg::UNL2_DATA);
		op(fcpc_pkg::FCPC_OP_RAW, fcpc_pkg::UNL1_ADDR, fcpc_pkg::CMD_PROGRAM);
		op(fcpc_pkg::FCPC_OP_RAW, 18'h00009, 8'h5a);
		rd_chk(18'h00009, 8'h5a);
		av_wr(4'h9, 32'hffffffff);
		av_rd(4'h9, v);
		check("unmapped read", v, 32'h0);
		end_sim();
	end
endmodule : fcpc_ctrl_tb
`default_nettype wire
